// File: adc_dual_unit_trigger.sv
// How it works
// R1 - Repeat mode raises completion interrupt every interval-field-plus-one conversions.
// R2 - Repeat mode stores results in slots zero to interval, then wraps.
// R3 - Scan mode starts at start channel, covers width-field-plus-one channels (up to channel 3), result per channel.
// R4 - Controller drives separate unit A and unit B start triggers, two modes.
// R5 - Source select picks software pulse, timer or external trigger.
// R6 - Interleave forwards trigger to unit A, then unit B after delay.
// R7 - Software sets interleave select and trigger enable to run interleave.
// R8 - Writing one to software trigger bit makes a single pulse.
// R9 - Unit A start launches delay counter; unit B fires at programmed count.
// R10 - Disabling after unit B still lets unit B result store, then stops.
// R11 - Disabling between unit A and unit B suppresses unit B and stops.
// R12 - Resume needs both bits set and an active trigger source.
// R13 - Software clears interleave select, sets enable for trigger start mode.
// R14 - Trigger start mode alternates triggers A then B, starting with A.
// R15 - Timer source triggers on the falling edge of the timer pulse.
// R16 - Each external trigger event gives the next alternating unit trigger.
// R17 - Software stops by clearing enable, no writes during operation.
// R18 - Next trigger must wait until unit B triggered and unit A done; the code waits only for the unit B trigger.
// R19 - Delay counter clears and halts after unit B, restarts on unit A.
// R20 - Alternation pointer returns to unit A when enable is cleared.
`timescale 1ns/1ns
`default_nettype none
module adc_dual_unit_trigger
    import adc_dual_pkg::*;
#(
    parameter int DELAY_WIDTH = DELAY_W
) (
    input wire logic i_core_clk, // Converter clock, 20 MHz
    input wire logic i_rst_n, // Asynchronous reset
    input wire logic i_hsel, // AHB slave select
    input wire logic [31:0] i_haddr, // AHB address
    input wire logic [1:0] i_htrans, // AHB transfer type
    input wire logic i_hwrite, // AHB write
    input wire logic [2:0] i_hsize, // AHB size
    input wire logic [31:0] i_hwdata, // AHB write data
    input wire logic i_hready, // AHB bus ready
    output logic [31:0] o_hrdata, // AHB read data
    output logic o_hreadyout, // AHB slave ready
    output logic o_hresp, // AHB response
    input wire logic i_timer_trig, // Timer trigger pin
    input wire logic i_ext_trig, // External trigger pin
    input wire conv_t i_conv_a, // Unit A conversion done
    input wire conv_t i_conv_b, // Unit B conversion done
    output logic o_start_a, // Unit A start pulse
    output logic o_start_b, // Unit B start pulse
    output logic o_int_a, // Unit A completion interrupt
    output logic o_int_b, // Unit B completion interrupt
    output logic o_wr_a, // Unit A result write strobe
    output logic [2:0] o_reg_a, // Unit A result register index
    output logic [15:0] o_data_a, // Unit A result data
    output logic o_wr_b, // Unit B result write strobe
    output logic [2:0] o_reg_b, // Unit B result register index
    output logic [15:0] o_data_b // Unit B result data
);

    typedef struct packed {
        logic [2:0] tim_s;
        logic [2:0] ext_s;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
        logic ilv;
        logic ten;
        trig_src_t src;
        logic [DELAY_WIDTH-1:0] delay;
        logic [15:0] mode_a;
        logic [15:0] mode_b;
        logic sw_pulse;
        ilv_state_t st;
        logic [DELAY_WIDTH-1:0] cnt;
        logic next_b;
        logic start_a;
        logic start_b;
        place_t pa;
        place_t pb;
        logic int_a;
        logic int_b;
        logic wr_a;
        logic wr_b;
        logic [2:0] reg_a;
        logic [2:0] reg_b;
        logic [15:0] data_a;
        logic [15:0] data_b;
    } state_t;

    state_t q, d;
    logic trig;
    logic run;

    // ==========================================================
    // Placement of a finished conversion into a result register
    function automatic place_t next_place(input place_t p, input logic [15:0] m,
                                          output logic [2:0] idx, output logic irq);
        place_t n;
        logic [2:0] itm;
        logic [1:0] sta;
        logic [1:0] last;
        logic [1:0] cur;
        n = p;
        itm = m[ITM_LSB +: 3];
        sta = m[SCAN_STA_LSB +: 2];
        last = 2'(sta + m[SCAN_AREA_LSB +: 2]);
        // A pointer below the start channel (after reset) begins at the start channel
        cur = (p.chan < sta) ? sta : p.chan;
        idx = 3'b000;
        irq = 1'b0;
        if (m[SCAN_BIT]) begin
            idx = {1'b0, cur}; // R3
            irq = (cur == last) || (cur == 2'd3); // R3
            n.chan = irq ? sta : 2'(cur + 2'd1); // R3
        end else if (m[REPEAT_BIT]) begin
            idx = p.slot; // R2
            irq = (p.slot >= itm); // R1
            n.slot = irq ? 3'd0 : 3'(p.slot + 3'd1); // R2
        end else begin
            // Single conversion: every result goes to register zero
            irq = 1'b1;
        end
        return n;
    endfunction : next_place

    // ==========================================================
    // Trigger selection
    always_comb begin
        run = q.ten;
        // Pin edges are judged between the second and third stages only
        unique case (q.src)
            SRC_SOFTWARE: trig = q.sw_pulse; // R5 R8
            SRC_TIMER: trig = q.tim_s[2] & ~q.tim_s[1]; // R5 R15
            SRC_EXTERNAL: trig = ~q.ext_s[2] & q.ext_s[1]; // R5 R16
            default: trig = 1'b0;
        endcase
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [2:0] ia;
        logic [2:0] ib;
        logic qa;
        logic qb;
        logic wr_ok;
        ia = 3'b000;
        ib = 3'b000;
        qa = 1'b0;
        qb = 1'b0;
        wr_ok = 1'b0;
        d = q;
        d.tim_s = {q.tim_s[1:0], i_timer_trig};
        d.ext_s = {q.ext_s[1:0], i_ext_trig};
        d.sw_pulse = 1'b0;
        d.start_a = 1'b0;
        d.start_b = 1'b0;
        d.int_a = 1'b0;
        d.int_b = 1'b0;
        d.wr_a = 1'b0;
        d.wr_b = 1'b0;

        // ==========================================================
        // AHB-Lite slave: zero wait states, data phase follows address phase
        wr_ok = q.ap_valid && q.ap_write;
        if (wr_ok) begin
            unique case (q.ap_addr)
                CTRL_ONE_ADDR: d.sw_pulse = i_hwdata[SW_TRIG_BIT]; // R8
                CTRL_TWO_ADDR: begin
                    d.ilv = i_hwdata[ILV_BIT];
                    d.ten = i_hwdata[TEN_BIT];
                    d.src = trig_src_t'(i_hwdata[SRC_LSB +: 2]);
                end
                CTRL_THREE_ADDR: d.delay = i_hwdata[DELAY_WIDTH-1:0];
                UNIT_A_MODE_ADDR: d.mode_a = i_hwdata[15:0];
                UNIT_B_MODE_ADDR: d.mode_b = i_hwdata[15:0];
                default: d.sw_pulse = 1'b0;
            endcase
        end
        d.ap_valid = i_hsel && i_hready && i_htrans[1];
        d.ap_write = i_hwrite;
        d.ap_addr = i_haddr[7:0];
        // ==========================================================
        // Read data is registered so that it stands through the data phase
        d.rdata = 32'h0000_0000;
        if (i_hsel && i_hready && i_htrans[1] && !i_hwrite) begin
            unique case (i_haddr[7:0])
                CTRL_TWO_ADDR: d.rdata = 32'({q.src, 2'b00, q.ten, q.ilv});
                CTRL_THREE_ADDR: d.rdata = 32'(q.delay);
                UNIT_A_MODE_ADDR: d.rdata = {16'h0000, q.mode_a};
                UNIT_B_MODE_ADDR: d.rdata = {16'h0000, q.mode_b};
                STATUS_ADDR: d.rdata = 32'({q.pb, q.pa, q.next_b, q.st});
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // ==========================================================
        // Dual-unit sequencing
        // Triggers that arrive while unit B is pending are ignored
        if (!run || !q.ilv) begin
            d.st = ST_IDLE; // R11 R19
            d.cnt = '0; // R19
        end
        if (!run) begin
            d.next_b = 1'b0; // R20
        end
        if (run && q.ilv) begin // R7 R12
            unique case (q.st)
                ST_IDLE: if (trig) begin
                    d.start_a = 1'b1; // R4 R6
                    d.st = ST_WAIT_B; // R9
                    d.cnt = '0; // R19
                end
                ST_WAIT_B: if (q.cnt >= q.delay) begin
                    d.start_b = 1'b1; // R6 R9
                    d.st = ST_IDLE;
                    d.cnt = '0; // R19
                end else begin
                    d.cnt = q.cnt + 1'b1; // R9
                end
            endcase
        end else if (run && trig) begin // R13
            d.start_a = ~q.next_b; // R14
            d.start_b = q.next_b; // R14
            d.next_b = ~q.next_b; // R14
        end

        // ==========================================================
        // Result placement; unit B results always stored (R10)
        d.pa = next_place(q.pa, q.mode_a, ia, qa);
        d.pb = next_place(q.pb, q.mode_b, ib, qb);
        if (!i_conv_a.done) begin
            d.pa = q.pa;
        end
        if (!i_conv_b.done) begin
            d.pb = q.pb;
        end
        d.wr_a = i_conv_a.done;
        d.reg_a = ia;
        d.data_a = i_conv_a.data;
        d.int_a = i_conv_a.done & qa; // R1
        d.wr_b = i_conv_b.done; // R10
        d.reg_b = ib;
        d.data_b = i_conv_b.data;
        d.int_b = i_conv_b.done & qb; // R1
    end

    // ==========================================================
    // State register
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '{
                tim_s: 3'b000,
                ext_s: 3'b000,
                ap_valid: 1'b0,
                ap_write: 1'b0,
                ap_addr: 8'h00,
                rdata: 32'h0000_0000,
                ilv: 1'b0,
                ten: 1'b0,
                src: SRC_SOFTWARE,
                delay: DELAY_WIDTH'(DELAY_RST),
                mode_a: MODE_RST,
                mode_b: MODE_RST,
                sw_pulse: 1'b0,
                st: ST_IDLE,
                cnt: '0,
                next_b: 1'b0,
                start_a: 1'b0,
                start_b: 1'b0,
                pa: '0,
                pb: '0,
                int_a: 1'b0,
                int_b: 1'b0,
                wr_a: 1'b0,
                wr_b: 1'b0,
                reg_a: 3'b000,
                reg_b: 3'b000,
                data_a: 16'h0000,
                data_b: 16'h0000
            };
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_hrdata = q.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_start_a = q.start_a;
    assign o_start_b = q.start_b;
    assign o_int_a = q.int_a;
    assign o_int_b = q.int_b;
    assign o_wr_a = q.wr_a;
    assign o_reg_a = q.reg_a;
    assign o_data_a = q.data_a;
    assign o_wr_b = q.wr_b;
    assign o_reg_b = q.reg_b;
    assign o_data_b = q.data_b;

endmodule : adc_dual_unit_trigger
`default_nettype wire

// File: adc_dual_pkg.sv
package adc_dual_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] CTRL_ONE_ADDR = 8'h00;
    localparam logic [7:0] CTRL_TWO_ADDR = 8'h04;
    localparam logic [7:0] CTRL_THREE_ADDR = 8'h08;
    localparam logic [7:0] UNIT_A_MODE_ADDR = 8'h0C;
    localparam logic [7:0] UNIT_B_MODE_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h14;

    // ==========================================================
    // Field positions
    localparam int SW_TRIG_BIT = 0;
    localparam int ILV_BIT = 0;
    localparam int TEN_BIT = 1;
    localparam int SRC_LSB = 4;
    localparam int ITM_LSB = 0;
    localparam int REPEAT_BIT = 4;
    localparam int SCAN_BIT = 5;
    localparam int SCAN_STA_LSB = 8;
    localparam int SCAN_AREA_LSB = 12;
    localparam int DELAY_W = 8;

    // ==========================================================
    // Reset values
    localparam logic [DELAY_W-1:0] DELAY_RST = 8'h00;
    localparam logic [15:0] MODE_RST = 16'h0000;

    // Trigger source encoding
    typedef enum logic [1:0] {
        SRC_SOFTWARE = 2'b00,
        SRC_TIMER = 2'b01,
        SRC_EXTERNAL = 2'b10
    } trig_src_t;

    // Interleave sequencer states, Gray along idle -> wait -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_B = 2'b01
    } ilv_state_t;

    // Per-unit placement state
    typedef struct packed {
        logic [2:0] slot;
        logic [1:0] chan;
    } place_t;

    // Conversion-done event from a unit
    typedef struct packed {
        logic done;
        logic [15:0] data;
    } conv_t;

endpackage : adc_dual_pkg

// File: adc_dual_checker.sv
`timescale 1ns/1ns
`default_nettype none
module adc_dual_checker
    import adc_dual_pkg::*;
(
    input wire logic i_core_clk, // Clock
    input wire logic i_rst_n, // Reset, active low
    input wire conv_t i_conv_a, // Unit A done
    input wire conv_t i_conv_b, // Unit B done
    input wire logic o_start_a, // Unit A start
    input wire logic o_start_b, // Unit B start
    input wire logic o_int_a, // Unit A interrupt
    input wire logic o_int_b, // Unit B interrupt
    input wire logic o_wr_a, // Unit A store
    input wire logic o_wr_b, // Unit B store
    input wire logic [15:0] o_data_a, // Unit A data
    input wire logic [15:0] o_data_b // Unit B data
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_store_a;
        o_wr_a && (o_data_a == $past(i_conv_a.data));
    endsequence
    sequence s_store_b;
        o_wr_b && (o_data_b == $past(i_conv_b.data));
    endsequence
    chk_store_a: assert property (i_conv_a.done |=> s_store_a)
        else $error("unit A result not stored");
    chk_store_b: assert property (i_conv_b.done |=> s_store_b)
        else $error("unit B result not stored");
    chk_wr_cause_a: assert property (o_wr_a |-> $past(i_conv_a.done))
        else $error("unit A store without result");
    chk_wr_cause_b: assert property (o_wr_b |-> $past(i_conv_b.done))
        else $error("unit B store without result");
    chk_int_wr_a: assert property (o_int_a |-> o_wr_a)
        else $error("unit A interrupt without store");
    chk_int_wr_b: assert property (o_int_b |-> o_wr_b)
        else $error("unit B interrupt without store");
    chk_pulse_a: assert property (o_start_a |=> !o_start_a)
        else $error("unit A start longer than a pulse");
    chk_pulse_b: assert property (o_start_b |=> !o_start_b)
        else $error("unit B start longer than a pulse");
    chk_ab_apart: assert property (!(o_start_a && o_start_b))
        else $error("both starts together");
endmodule : adc_dual_checker
`default_nettype wire

// File: adc_dual_units.sv
`timescale 1ns/1ns
`default_nettype none
module adc_dual_units
    import adc_dual_pkg::*;
#(
    parameter int LAT = 4
) (
    input wire logic i_clk, // Converter clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_start_a, // Unit A start
    input wire logic i_start_b, // Unit B start
    output var conv_t o_conv_a, // Unit A done and result
    output var conv_t o_conv_b // Unit B done and result
);
    logic [LAT-1:0] busy_a, busy_b;
    logic [15:0] cnt;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_a <= '0;
            busy_b <= '0;
            cnt <= 16'h0000;
        end else begin
            busy_a <= {busy_a[LAT-2:0], i_start_a};
            busy_b <= {busy_b[LAT-2:0], i_start_b};
            cnt <= cnt + 16'h0001;
        end
    end
    // Data changes every cycle so a stale sample never matches
    assign o_conv_a = {busy_a[LAT-1], cnt};
    assign o_conv_b = {busy_b[LAT-1], ~cnt};
endmodule : adc_dual_units
`default_nettype wire

// File: adc_dual_unit_trigger_bench.sv
`timescale 1ns/1ns
`default_nettype none
bind adc_dual_unit_trigger adc_dual_checker u_chk (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_conv_a(i_conv_a), .i_conv_b(i_conv_b), .o_start_a(o_start_a),
    .o_start_b(o_start_b), .o_int_a(o_int_a), .o_int_b(o_int_b), .o_wr_a(o_wr_a),
    .o_wr_b(o_wr_b), .o_data_a(o_data_a), .o_data_b(o_data_b));
module adc_dual_unit_trigger_bench
    import adc_dual_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, tim = 1'b0, ext = 1'b0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
    logic [1:0] htrans = 2'b00;
    logic hready, hresp, start_a, start_b, int_a, int_b, wr_a, wr_b;
    logic [2:0] reg_a, reg_b;
    conv_t conv_a, conv_b;
    int n_mismatch = 0, checks_done = 0, cyc = 0, na = 0, nb = 0, ta = 0, tb = 0, a0, b0;
    logic [3:0] qa[$], qb[$];
    adc_dual_unit_trigger dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_timer_trig(tim), .i_ext_trig(ext), .i_conv_a(conv_a), .i_conv_b(conv_b),
        .o_start_a(start_a), .o_start_b(start_b), .o_int_a(int_a), .o_int_b(int_b),
        .o_wr_a(wr_a), .o_reg_a(reg_a), .o_data_a(), .o_wr_b(wr_b), .o_reg_b(reg_b),
        .o_data_b());
    adc_dual_units units (.i_clk(clk), .i_rst_n(rst_n), .i_start_a(start_a),
        .i_start_b(start_b), .o_conv_a(conv_a), .o_conv_b(conv_b));
    initial begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        na <= na + int'(start_a === 1'b1);
        nb <= nb + int'(start_b === 1'b1);
        ta <= (start_a === 1'b1) ? cyc : ta;
        tb <= (start_b === 1'b1) ? cyc : tb;
        if (wr_a === 1'b1) qa.push_back({int_a, reg_a});
        if (wr_b === 1'b1) qb.push_back({int_b, reg_b});
        if (cyc == 4000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    task automatic chk(input bit ok, input string m);
        checks_done++;
        if (!ok) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask : chk
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : bus
    task automatic trig_wait(input int n);
        bus(1'b1, CTRL_ONE_ADDR, 32'h0000_0001);
        for (int i = 0; i < 60 && nb == n; i++) @(posedge clk);
    endtask : trig_wait
    task automatic t_regs;
        bus(1'b0, STATUS_ADDR, 32'h0000_0000);
        chk(rd === 32'h0000_0000 && hresp === 1'b0, "status not idle or not OKAY");
        bus(1'b1, CTRL_THREE_ADDR, 32'h0000_00A5);
        bus(1'b0, CTRL_THREE_ADDR, 32'h0000_0000);
        chk(rd === 32'h0000_00A5, "delay count readback");
        bus(1'b0, CTRL_ONE_ADDR, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "software trigger bit reads 1");
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "unmapped read not zero");
        $display("t_regs done");
    endtask : t_regs
    task automatic t_place;
        bus(1'b1, UNIT_A_MODE_ADDR, 32'h0000_0012);
        bus(1'b1, UNIT_B_MODE_ADDR, 32'h0000_2130);
        bus(1'b1, CTRL_THREE_ADDR, 32'h0000_0001);
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0003);
        repeat (6) begin
            trig_wait(nb);
            repeat (10) @(posedge clk);
        end
        chk(qa.size() == 6 && qb.size() == 6, "result count");
        for (int k = 0; k < 6; k++) begin
            chk(qa[k] === {1'(k % 3 == 2), 3'(k % 3)}, "repeat slot or interrupt");
            chk(qb[k] === {1'(k % 3 == 2), 3'(k % 3 + 1)}, "scan channel");
        end
        $display("t_place done");
    endtask : t_place
    task automatic t_ilv;
        bus(1'b1, CTRL_THREE_ADDR, 32'h0000_0003);
        repeat (2) begin
            trig_wait(nb);
            chk(tb - ta == 4, "unit B delay");
            repeat (12) @(posedge clk);
        end
        bus(1'b1, CTRL_THREE_ADDR, 32'h0000_0014);
        b0 = nb;
        bus(1'b1, CTRL_ONE_ADDR, 32'h0000_0001);
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk(nb == b0, "unit B not suppressed");
        a0 = qb.size();
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0003);
        trig_wait(nb);
        chk(nb == b0 + 1 && tb - ta == 21, "no resume");
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0000);
        repeat (12) @(posedge clk);
        chk(qb.size() == a0 + 1, "unit B result lost after stop");
        $display("t_ilv done");
    endtask : t_ilv
    task automatic t_alt;
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0012);
        a0 = na;
        b0 = nb;
        for (int k = 0; k < 2; k++) begin
            tim <= 1'b1;
            repeat (8) @(posedge clk);
            chk(na == a0 + k && nb == b0, "timer rising edge used");
            tim <= 1'b0;
            repeat (8) @(posedge clk);
            chk(na == a0 + 1 && nb == b0 + k, "alternation");
        end
        tim <= 1'b1;
        repeat (8) @(posedge clk);
        tim <= 1'b0;
        repeat (8) @(posedge clk);
        chk(na == a0 + 2 && nb == b0 + 1, "third trigger not on unit A");
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0000);
        bus(1'b1, CTRL_TWO_ADDR, 32'h0000_0022);
        ext <= 1'b1;
        repeat (8) @(posedge clk);
        ext <= 1'b0;
        repeat (8) @(posedge clk);
        chk(na == a0 + 3 && nb == b0 + 1, "external or pointer reset");
        $display("t_alt done");
    endtask : t_alt
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_place();
        t_ilv();
        t_alt();
        print_verdict();
    end
endmodule : adc_dual_unit_trigger_bench
`default_nettype wire
